/* File: msc_chopper_cfg.sv */
// Microstep position keeping and chopper configuration decoding with a
// classic Wishbone register slave.
// Assumes one 50 MHz clock, a synchronous reset, step/dir pins from outside
// the clock domain and ramp steps and velocity updates from the same clock.
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "msc_defs.svh"

module msc_chopper_cfg #(
  parameter int VEL_W = 24,
  parameter int CUR_W = 8
) (
  input  wire logic             CLK,
  input  wire logic             RESET,
  input  wire logic             WB_CYC_I,
  input  wire logic             WB_STB_I,
  input  wire logic             WB_WE_I,
  input  wire logic [7:0]       WB_ADR_I,
  input  wire logic [3:0]       WB_SEL_I,
  input  wire logic [31:0]      WB_DAT_I,
  output logic [31:0]           WB_DAT_O,
  output logic                  WB_ACK_O,
  input  wire logic             STEP_PIN,
  input  wire logic             DIR_PIN,
  input  wire logic             RAMP_STEP,
  input  wire logic             RAMP_DIR,
  input  wire logic signed [VEL_W-1:0] VELOCITY,
  input  wire logic             VEL_UPDATE,
  input  wire logic [CUR_W-1:0] TABLE_CUR,
  output logic [9:0]            MSCNT,
  output logic                  FULLSTEP,
  output logic [CUR_W-1:0]      TARGET_CUR,
  output logic                  CHM,
  output logic                  FAST_DECAY_FIELD,
  output logic [4:0]            OFF_TIME_SETTING,
  output logic                  VSENSE_HIGH
);

  msc_pkg::msc_cfg_s  cfg_q;
  msc_pkg::msc_chop_s chop_d;
  msc_pkg::msc_chop_s chop_q;
  msc_pkg::msc_step_e step_q;
  msc_pkg::msc_step_e step_d;

  logic [22:0]       vhigh_q;
  logic              sd_mode_q;
  logic              ack_q;
  logic [31:0]       rdata_d;
  logic [31:0]       rdata_q;
  logic              req;
  logic              wr;
  logic [31:0]       wmask;
  logic [2:0]        step_sync_q;
  logic [2:0]        dir_sync_q;
  logic              step_lvl_q;
  logic              dir_lvl_q;
  logic              pin_rise;
  logic              pin_fall;
  logic              raw_step;
  logic              raw_dir;
  logic              interp_on;
  logic              sub_pulse;
  logic              sub_dir;
  logic              over_q;
  logic [VEL_W-1:0]  vel_abs;
  logic [9:0]        pos_q;
  logic [9:0]        inc;
  logic              do_step;
  logic              step_dir;
  logic              at_45;
  logic              want_full;
  logic [CUR_W-1:0]  cur45_q;
  logic [CUR_W-1:0]  target_q;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, ack drops in the cycle after it is given.
  assign req      = WB_CYC_I && WB_STB_I && !ack_q;
  assign wr       = req && WB_WE_I;
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdata_q;
  assign wmask    = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  logic [31:0] cfg_word;
  logic [31:0] cfg_new;

  // Reserved and unused bits read as zero whatever the host wrote.
  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[`MSC_BIT_DEDGE]              = cfg_q.dedge;
    cfg_word[`MSC_BIT_INTPOL]             = cfg_q.intpol;
    cfg_word[`MSC_MRES_HI:`MSC_MRES_LO]   = cfg_q.mres;
    cfg_word[`MSC_BIT_VHIGHCHM]           = cfg_q.vhighchm;
    cfg_word[`MSC_BIT_VHIGHFS]            = cfg_q.vhighfs;
    cfg_word[`MSC_BIT_VSENSE]             = cfg_q.vsense;
    cfg_word[`MSC_BIT_CHM]                = cfg_q.chm;
    cfg_word[`MSC_BIT_FAST_DECAY]         = cfg_q.fast_decay_field;
    cfg_word[`MSC_OFF_TIME_HI:`MSC_OFF_TIME_LO] = cfg_q.off_time_setting;
    cfg_new  = merge(cfg_word, WB_DAT_I, wmask);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      cfg_q <= '0;
    end else if (wr && WB_ADR_I == `MSC_ADR_CHOPCONF) begin
      cfg_q.dedge    <= cfg_new[`MSC_BIT_DEDGE];
      cfg_q.intpol   <= cfg_new[`MSC_BIT_INTPOL];
      cfg_q.mres     <= cfg_new[`MSC_MRES_HI:`MSC_MRES_LO];
      cfg_q.vhighchm <= cfg_new[`MSC_BIT_VHIGHCHM];
      cfg_q.vhighfs  <= cfg_new[`MSC_BIT_VHIGHFS];
      cfg_q.vsense   <= cfg_new[`MSC_BIT_VSENSE];
      cfg_q.chm      <= cfg_new[`MSC_BIT_CHM];
      cfg_q.fast_decay_field <= cfg_new[`MSC_BIT_FAST_DECAY];
      cfg_q.off_time_setting <= cfg_new[`MSC_OFF_TIME_HI:`MSC_OFF_TIME_LO];
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      vhigh_q <= `MSC_VHIGH_RST;
    end else if (wr && WB_ADR_I == `MSC_ADR_VHIGH) begin
      vhigh_q <= 23'(merge({9'h000, vhigh_q}, WB_DAT_I, wmask));
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      sd_mode_q <= 1'b0;
    end else if (wr && WB_ADR_I == `MSC_ADR_CTRL && WB_SEL_I[0]) begin
      sd_mode_q <= WB_DAT_I[`MSC_BIT_SD_MODE];
    end
  end

  always_comb begin
    case (WB_ADR_I)
      `MSC_ADR_CHOPCONF: rdata_d = cfg_word;
      `MSC_ADR_VHIGH:    rdata_d = {9'h000, vhigh_q};
      `MSC_ADR_CTRL:     rdata_d = {31'h0000_0000, sd_mode_q};
      `MSC_ADR_STATUS:   rdata_d = {16'h0000, over_q, chop_q.chm, FULLSTEP, 3'h0, pos_q};
      default:           rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rdata_q <= 32'h0000_0000;
    end else if (req && !WB_WE_I) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Step/dir pins: three flip-flops, a level counts once stages two and three
  // agree, which rejects a single-cycle glitch on the pin.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      step_sync_q <= 3'h0;
      dir_sync_q  <= 3'h0;
    end else begin
      step_sync_q <= {step_sync_q[1:0], STEP_PIN};
      dir_sync_q  <= {dir_sync_q[1:0], DIR_PIN};
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      step_lvl_q <= 1'b0;
      dir_lvl_q  <= 1'b0;
    end else begin
      if (step_sync_q[1] == step_sync_q[2]) begin
        step_lvl_q <= step_sync_q[2];
      end
      if (dir_sync_q[1] == dir_sync_q[2]) begin
        dir_lvl_q <= dir_sync_q[2];
      end
    end
  end

  assign pin_rise = (step_sync_q[1] == step_sync_q[2]) && step_sync_q[2] && !step_lvl_q;
  assign pin_fall = (step_sync_q[1] == step_sync_q[2]) && !step_sync_q[2] && step_lvl_q;

  always_comb begin
    if (sd_mode_q) begin
      raw_step = pin_rise || (cfg_q.dedge && pin_fall);
      raw_dir  = dir_lvl_q;
    end else begin
      raw_step = RAMP_STEP;
      raw_dir  = RAMP_DIR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interpolation applies only at 16 microsteps with step/dir input.
  assign interp_on = cfg_q.intpol && sd_mode_q && cfg_q.mres == `MSC_MRES_16 &&
                     step_q == msc_pkg::MSC_ST_MICRO;

  msc_interp #(
    .PERIOD_W (20)
  ) u_interp (
    .clk        (CLK),
    .reset      (RESET),
    .enable     (interp_on),
    .step_pulse (raw_step),
    .step_dir   (raw_dir),
    .sub_pulse  (sub_pulse),
    .sub_dir    (sub_dir)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Velocity threshold, judged on each velocity update.
  assign vel_abs = VELOCITY[VEL_W-1] ? VEL_W'(-VELOCITY) : VEL_W'(VELOCITY);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      over_q <= 1'b0;
    end else if (VEL_UPDATE) begin
      over_q <= vel_abs > VEL_W'(vhigh_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Microstep position and the full-step switchover.
  assign at_45     = pos_q[7:0] == `MSC_POS_45;
  assign want_full = cfg_q.vhighfs && over_q;

  always_comb begin
    step_d = step_q;
    case (step_q)
      msc_pkg::MSC_ST_MICRO: if (want_full && at_45) step_d = msc_pkg::MSC_ST_FULL;
      msc_pkg::MSC_ST_FULL:  if (!want_full && at_45) step_d = msc_pkg::MSC_ST_MICRO;
      default:               step_d = msc_pkg::MSC_ST_MICRO;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      step_q <= msc_pkg::MSC_ST_MICRO;
    end else begin
      step_q <= step_d;
    end
  end

  // Values above eight are not defined; they are held at full step.
  always_comb begin
    if (step_q == msc_pkg::MSC_ST_FULL) begin
      inc = `MSC_FULL_INC;
    end else if (interp_on) begin
      inc = 10'h001;
    end else if (cfg_q.mres > `MSC_MRES_FULL) begin
      inc = `MSC_FULL_INC;
    end else begin
      inc = 10'h001 << cfg_q.mres;
    end
    do_step  = interp_on ? sub_pulse : raw_step;
    step_dir = interp_on ? sub_dir : raw_dir;
  end

  // The position only moves while stepping, so a transition found at 45
  // degrees lands before the next step is taken.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pos_q <= `MSC_POS_RST;
    end else if (do_step) begin
      pos_q <= step_dir ? pos_q - inc : pos_q + inc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Coil target: the table value caught at 45 degrees is held in full step.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cur45_q <= '0;
    end else if (step_q == msc_pkg::MSC_ST_MICRO && at_45) begin
      cur45_q <= TABLE_CUR;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      target_q <= '0;
    end else if (step_q == msc_pkg::MSC_ST_FULL) begin
      target_q <= cur45_q;
    end else begin
      target_q <= TABLE_CUR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chopper settings; doubling keeps the chopper frequency from doubling.
  always_comb begin
    chop_d.chm              = cfg_q.chm;
    chop_d.fast_decay_field = cfg_q.fast_decay_field;
    chop_d.off_time_setting = {1'b0, cfg_q.off_time_setting};
    if (cfg_q.vhighchm && over_q) begin
      chop_d.chm              = 1'b1;
      chop_d.fast_decay_field = 1'b0;
      chop_d.off_time_setting = {cfg_q.off_time_setting, 1'b0};
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      chop_q <= '0;
    end else begin
      chop_q <= chop_d;
    end
  end

  assign MSCNT            = pos_q;
  assign FULLSTEP         = step_q == msc_pkg::MSC_ST_FULL;
  assign TARGET_CUR       = target_q;
  assign CHM              = chop_q.chm;
  assign FAST_DECAY_FIELD = chop_q.fast_decay_field;
  assign OFF_TIME_SETTING = chop_q.off_time_setting;
  assign VSENSE_HIGH      = cfg_q.vsense;

endmodule

`default_nettype wire

/* File: msc_defs.svh */
// Register offsets, field positions, reset values, resolution codes and step constants of the
// microstep and chopper configuration block.
// Assumes a 32-bit classic Wishbone slave with byte addresses on an 8-bit bus.
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH

`define MSC_ADR_CHOPCONF     8'h00
`define MSC_ADR_VHIGH        8'h04
`define MSC_ADR_CTRL         8'h08
`define MSC_ADR_STATUS       8'h0C

`define MSC_BIT_DEDGE        29
`define MSC_BIT_INTPOL       28
`define MSC_MRES_HI          27
`define MSC_MRES_LO          24
`define MSC_BIT_VHIGHCHM     19
`define MSC_BIT_VHIGHFS      18
`define MSC_BIT_VSENSE       17
`define MSC_BIT_CHM          14
`define MSC_BIT_FAST_DECAY   12
`define MSC_OFF_TIME_HI      3
`define MSC_OFF_TIME_LO      0
`define MSC_BIT_SD_MODE      0

`define MSC_CHOPCONF_RST     32'h0000_0000
`define MSC_VHIGH_RST        23'h00_0000
`define MSC_MRES_NATIVE      4'h0
`define MSC_MRES_16          4'h4
`define MSC_MRES_FULL        4'h8
`define MSC_POS_45           8'h80
`define MSC_POS_RST          10'h000
`define MSC_FULL_INC         10'h100
`define MSC_INTERP_SUBSTEPS  5'h10

`endif

/* File: msc_pkg.sv */
// Types shared by the microstep and chopper configuration block.
// Assumes msc_defs.svh holds every number.
package msc_pkg;

  typedef struct packed {
    logic       dedge;
    logic       intpol;
    logic [3:0] mres;
    logic       vhighchm;
    logic       vhighfs;
    logic       vsense;
    logic       chm;
    logic       fast_decay_field;
    logic [3:0] off_time_setting;
  } msc_cfg_s;

  typedef struct packed {
    logic       chm;
    logic       fast_decay_field;
    logic [4:0] off_time_setting;
  } msc_chop_s;

  typedef enum logic [1:0] {
    MSC_ST_MICRO = 2'b01,
    MSC_ST_FULL  = 2'b10
  } msc_step_e;

endpackage

/* File: msc_interp.sv */
// Spreads each incoming step into sixteen unit microsteps over the measured
// step period. Assumes step pulses are one cycle long and on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "msc_defs.svh"

module msc_interp #(
  parameter int PERIOD_W = 20
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic enable,
  input  wire logic step_pulse,
  input  wire logic step_dir,
  output logic      sub_pulse,
  output logic      sub_dir
);

  logic [PERIOD_W-1:0] period_q;
  logic [PERIOD_W-1:0] interval_q;
  logic [PERIOD_W-1:0] tick_q;
  logic [5:0]          pend_q;
  logic                dir_q;
  logic                fire;

  ////////////////////////////////////////////////////////////////////////////
  // An early step flushes the backlog at full rate; a step that arrives with 32 or more pending is dropped.
  assign fire      = enable && (pend_q != 6'h00) && ((tick_q >= interval_q) || pend_q > 6'h10);
  assign sub_pulse = fire;
  assign sub_dir   = dir_q;

  always_ff @(posedge clk) begin
    if (reset || !enable) begin
      period_q <= '0;
    end else if (step_pulse) begin
      period_q <= '0;
    end else if (period_q != '1) begin
      period_q <= period_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !enable) begin
      interval_q <= '0;
      dir_q      <= 1'b0;
    end else if (step_pulse) begin
      interval_q <= period_q >> 4;
      dir_q      <= step_dir;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !enable) begin
      tick_q <= '0;
    end else if (fire || step_pulse) begin
      tick_q <= '0;
    end else if (tick_q != '1) begin
      tick_q <= tick_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !enable) begin
      pend_q <= 6'h00;
    end else if (step_pulse && pend_q < 6'h20) begin
      pend_q <= pend_q + {1'b0, `MSC_INTERP_SUBSTEPS} - {5'h00, fire};
    end else if (fire) begin
      pend_q <= pend_q - 6'h01;
    end
  end

endmodule

`default_nettype wire

/* File: msc_chopper_cfg_asserts.sv */
// Port-level checks for the chopper configuration block.
// Assumes it is bound into msc_chopper_cfg and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module msc_chopper_cfg_asserts #(
  parameter int CUR_W = 8
) (
  input wire logic             CLK,
  input wire logic             RESET,
  input wire logic             WB_CYC_I,
  input wire logic             WB_STB_I,
  input wire logic             WB_ACK_O,
  input wire logic [31:0]      WB_DAT_O,
  input wire logic [9:0]       MSCNT,
  input wire logic             FULLSTEP,
  input wire logic [CUR_W-1:0] TABLE_CUR,
  input wire logic [CUR_W-1:0] TARGET_CUR
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("Request was not answered one cycle later.");
  ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("Acknowledge stood for more than one cycle.");
  ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I) && $past(WB_STB_I))
    else $error("Acknowledge without a request.");
  dat_quiet_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
    else $error("Read data not zero outside acknowledge.");
  full_at45_a: assert property ($changed(FULLSTEP) |-> $past(MSCNT[7:0]) == 8'h80)
    else $error("Step mode changed away from the 45 degree point.");
  full_size_a: assert property (FULLSTEP && $past(FULLSTEP) && $changed(MSCNT)
    |-> MSCNT[7:0] == $past(MSCNT[7:0]))
    else $error("Full step moved by other than 256.");
  cur_hold_a: assert property (FULLSTEP && $past(FULLSTEP) && $past(FULLSTEP, 2)
    |-> $stable(TARGET_CUR))
    else $error("Target current moved during full step.");
  cur_follow_a: assert property (!FULLSTEP && !$past(FULLSTEP) && !$past(RESET)
    |-> TARGET_CUR == $past(TABLE_CUR))
    else $error("Target current does not follow the table.");
endmodule

bind msc_chopper_cfg msc_chopper_cfg_asserts #(.CUR_W(CUR_W)) u_chk (
  .CLK(CLK), .RESET(RESET), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O), .MSCNT(MSCNT), .FULLSTEP(FULLSTEP),
  .TABLE_CUR(TABLE_CUR), .TARGET_CUR(TARGET_CUR));

`default_nettype wire

/* File: msc_step_src.sv */
// External step and direction source facing the block's pins.
// Assumes the bench asks for each edge with a one-cycle go pulse.
`timescale 1ns/1ps
`default_nettype none

module msc_step_src (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic go,
  input  wire logic dir,
  output logic      step_pin,
  output logic      dir_pin
);
  // Each go toggles the pin, so two gos make one full pulse; the bench
  // enables double edges only for the 8-unit moves in step/dir mode, and its random register test also sets them before step/dir mode is selected.
  always_ff @(posedge clk) begin
    if (reset) begin
      step_pin <= 1'b0;
    end else if (go) begin
      step_pin <= ~step_pin;
    end
  end

  always_ff @(posedge clk) begin
    dir_pin <= dir;
  end
endmodule

`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the chopper configuration block.
// Assumes msc_defs.svh and the design's default parameters.
`timescale 1ns/1ps
`default_nettype none
`include "msc_defs.svh"

module tb;
  logic clk, reset, cyc, stb, wem, go, dir, step_pin, dir_pin, ramp_step, vel_update;
  logic [7:0]  adr, table_cur, target_cur;
  logic [3:0]  sel;
  logic [31:0] dat, dat_o, rnd, cw;
  logic [23:0] velocity;
  logic [9:0]  mscnt, last, pos;
  logic [4:0]  off_o;
  logic        ack, fullstep, chm_o, fast_o, vsense_o;
  logic [31:0] rq[$];
  logic [9:0]  mq[$];
  int          mismatches, checked;

  msc_chopper_cfg u_dut (
    .CLK(clk), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(wem),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .STEP_PIN(step_pin), .DIR_PIN(dir_pin), .RAMP_STEP(ramp_step), .RAMP_DIR(1'b0),
    .VELOCITY(velocity), .VEL_UPDATE(vel_update), .TABLE_CUR(table_cur),
    .MSCNT(mscnt), .FULLSTEP(fullstep), .TARGET_CUR(target_cur), .CHM(chm_o),
    .FAST_DECAY_FIELD(fast_o), .OFF_TIME_SETTING(off_o), .VSENSE_HIGH(vsense_o));

  msc_step_src u_src (.clk(clk), .reset(reset), .go(go), .dir(dir),
    .step_pin(step_pin), .dir_pin(dir_pin));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] cfg(input logic de, ip, input logic [3:0] mr,
    input logic vc, vf, vs, ch, fdf, input logic [3:0] ot);
    return {2'b00, de, ip, mr, 4'h0, vc, vf, vs, 2'b00, ch, 1'b0, fdf, 8'h00, ot};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Reads note their expected data; the monitor below does the comparing.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] e);
    int n;
    n = 0;
    if (!we) rq.push_back(e);
    cyc <= 1'b1;
    stb <= 1'b1;
    wem <= we;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    // Only an ack or the watchdog ends this wait; the slave answers one cycle after it takes.
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    chk(32'(n), 32'h0000_0002);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic step(input logic ramp, input int d);
    if (d != 0) begin
      pos = pos + 10'(d);
      mq.push_back(pos);
    end
    if (ramp) ramp_step <= 1'b1;
    else go <= 1'b1;
    @(posedge clk);
    ramp_step <= 1'b0;
    go <= 1'b0;
    repeat (10) @(posedge clk);
  endtask

  task automatic vel(input int v);
    velocity <= 24'(v);
    vel_update <= 1'b1;
    @(posedge clk);
    vel_update <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Every position change must match the oldest noted one; unnoted moves fail.
  always @(posedge clk) begin
    if (ack === 1'b1 && wem === 1'b0 && rq.size() > 0) chk(dat_o, rq.pop_front());
    if (mscnt !== last && reset === 1'b0) begin
      if (mq.size() == 0) chk(32'(mscnt), 32'(last));
      else chk(32'(mscnt), 32'(mq.pop_front()));
    end
    last = mscnt;
    rnd <= lfsr(rnd);
    table_cur <= rnd[7:0];
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    {reset, cyc, stb, wem, go, dir, ramp_step, vel_update} = 8'hFF & 8'h80;
    {adr, sel, dat, velocity, table_cur} = '0;
    rnd = 32'h0d3c_a126;
    mismatches = 0;
    checked = 0;
    pos = 10'h000;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 20; a += 4) wb(1'b0, 8'(a), 32'h0000_0000, 32'h0000_0000);
    wb(1'b1, 8'h10, rnd, 32'h0000_0000);
    wb(1'b0, 8'h10, 32'h0000_0000, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      cw = rnd & 32'h3F0E_500F;
      wb(1'b1, `MSC_ADR_CHOPCONF, cw, 32'h0000_0000);
      wb(1'b0, `MSC_ADR_CHOPCONF, 32'h0000_0000, cw);
      chk(32'(vsense_o), 32'(cw[17]));
      repeat (7) @(posedge clk);
    end
    $display("test registers done");
    wb(1'b1, `MSC_ADR_CTRL, 32'h0000_0001, 32'h0000_0000);
    step(1'b1, 0);
    for (int m = 0; m < 9; m++) begin
      wb(1'b1, `MSC_ADR_CHOPCONF, cfg(0, 0, 4'(m), 0, 0, 0, 0, 0, 4'h0), 32'h0000_0000);
      step(1'b0, 1 << m);
      step(1'b0, 0);
    end
    wb(1'b1, `MSC_ADR_CHOPCONF, cfg(1, 0, 4'h3, 0, 0, 0, 0, 0, 4'h0), 32'h0000_0000);
    step(1'b0, 8);
    step(1'b0, 8);
    dir <= 1'b1;
    repeat (5) @(posedge clk);
    step(1'b0, -8);
    step(1'b0, -8);
    dir <= 1'b0;
    repeat (5) @(posedge clk);
    $display("test step sizes done");
    wb(1'b1, `MSC_ADR_CHOPCONF, cfg(0, 1, 4'h4, 0, 0, 0, 0, 0, 4'h0), 32'h0000_0000);
    for (int i = 0; i < 32; i++) begin
      pos = pos + 10'h001;
      mq.push_back(pos);
    end
    step(1'b0, 0);
    repeat (50) @(posedge clk);
    step(1'b0, 0);
    step(1'b0, 0);
    repeat (250) @(posedge clk);
    step(1'b0, 0);
    $display("test interpolation done");
    wb(1'b1, `MSC_ADR_VHIGH, 32'h0000_03E8, 32'h0000_0000);
    wb(1'b1, `MSC_ADR_CHOPCONF, cfg(0, 0, 4'h0, 1, 0, 0, 0, 1, 4'h5), 32'h0000_0000);
    vel(-1001);
    chk(32'({chm_o, fast_o, off_o}), 32'h0000_004A);
    vel(1000);
    chk(32'({chm_o, fast_o, off_o}), 32'h0000_0025);
    wb(1'b1, `MSC_ADR_CHOPCONF, cfg(0, 0, 4'h0, 0, 0, 0, 0, 1, 4'h5), 32'h0000_0000);
    vel(5000);
    chk(32'({chm_o, fast_o, off_o}), 32'h0000_0025);
    $display("test chopper switch done");
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    pos = 10'h000;
    @(posedge clk);
    wb(1'b1, `MSC_ADR_VHIGH, 32'h0000_0064, 32'h0000_0000);
    wb(1'b1, `MSC_ADR_CHOPCONF, cfg(0, 0, 4'h0, 1, 1, 0, 0, 1, 4'h3), 32'h0000_0000);
    vel(200);
    for (int i = 0; i < 127; i++) step(1'b1, 1);
    chk(32'(fullstep), 32'h0000_0000);
    step(1'b1, 1);
    chk(32'({fullstep, chm_o, fast_o, off_o}), 32'h0000_00C6);
    step(1'b1, 256);
    step(1'b1, 256);
    vel(50);
    chk(32'(fullstep), 32'h0000_0000);
    step(1'b1, 1);
    $display("test fullstep done");
    // Every noted move and read must have been seen by now.
    chk(32'(mq.size() + rq.size()), 32'h0000_0000);
    wrap_up();
  end
endmodule

`default_nettype wire
